// >>> hw/zero_compare_branch_unit.sv
// Branch resolution, delay-slot handling and slot checking for compare-against-zero branches
`timescale 1ns/10ps
module zero_compare_branch_unit (
    // Clock and reset
    input  wire logic                                                I_CLOCK,
    input  wire logic                                                I_RST,
    // Configuration
    input  wire logic                                                I_RELEASE6,
    // Branch issue
    input  wire logic                                                I_BRANCH_VALID,
    input  wire zero_compare_pkg::branch_req_t                       I_BRANCH,
    // Delay-slot instruction
    input  wire logic                                                I_SLOT_VALID,
    input  wire zero_compare_pkg::slot_class_t                       I_SLOT_CLASS,
    // Pipeline flush
    input  wire logic                                                I_FLUSH,
    // Issue handshake
    output logic                                                     O_READY,
    // Delay-slot outcome
    output logic                                                     O_SLOT_COMMIT,
    output logic                                                     O_SLOT_NULLIFY,
    output logic                                                     O_SLOT_UNPREDICTABLE,
    output logic                                                     O_RI_EXCEPTION,
    // Redirect
    output logic                                                     O_REDIRECT,
    output logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0]      O_TARGET,
    // Prediction hints
    output logic                                                     O_PREDICT_VALID,
    output logic                                                     O_PREDICT_STATIC_TAKEN,
    output logic                                                     O_PREDICTOR_LOOKUP,
    output logic                                                     O_PREDICTOR_UPDATE,
    output logic                                                     O_UPDATE_TAKEN
);

    zero_compare_pkg::unit_state_t                    state_reg;
    zero_compare_pkg::unit_state_t                    state_next;
    logic                                             taken_reg;
    logic                                             taken_next;
    logic                                             likely_reg;
    logic                                             likely_next;
    logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0] target_reg;
    logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0] target_next;
    logic                                             ready_reg;
    logic                                             ready_next;
    logic                                             commit_reg;
    logic                                             commit_next;
    logic                                             nullify_reg;
    logic                                             nullify_next;
    logic                                             unpred_reg;
    logic                                             unpred_next;
    logic                                             ri_reg;
    logic                                             ri_next;
    logic                                             redirect_reg;
    logic                                             redirect_next;
    logic                                             pred_valid_reg;
    logic                                             pred_valid_next;
    logic                                             pred_static_reg;
    logic                                             pred_static_next;
    logic                                             pred_lookup_reg;
    logic                                             pred_lookup_next;
    logic                                             pred_update_reg;
    logic                                             pred_update_next;
    logic                                             update_taken_reg;
    logic                                             update_taken_next;

    logic                                             cond_taken;
    logic                                             cond_likely;
    logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0] calc_target;
    logic                                             slot_is_xfer;
    logic                                             branch_fire;
    logic                                             slot_take;

    zero_compare_cond u_cond (
        .i_kind    (I_BRANCH.kind),
        .i_operand (I_BRANCH.operand),
        .o_taken   (cond_taken),
        .o_likely  (cond_likely)
    );

    branch_target_calc u_target (
        .i_pc     (I_BRANCH.pc),
        .i_offset (I_BRANCH.offset),
        .o_target (calc_target)
    );

    assign slot_is_xfer = zero_compare_pkg::is_control_transfer(I_SLOT_CLASS);
    assign branch_fire = (state_reg == zero_compare_pkg::ST_IDLE) && I_BRANCH_VALID && !I_FLUSH;
    assign slot_take   = (state_reg == zero_compare_pkg::ST_SLOT) && I_SLOT_VALID && !I_FLUSH;

    always_comb begin
        state_next        = state_reg;
        taken_next        = taken_reg;
        likely_next       = likely_reg;
        target_next       = target_reg;
        pred_static_next  = pred_static_reg;
        update_taken_next = update_taken_reg;
        commit_next       = 1'h0;
        nullify_next      = 1'h0;
        unpred_next       = 1'h0;
        ri_next           = 1'h0;
        redirect_next     = 1'h0;
        pred_valid_next   = 1'h0;
        pred_lookup_next  = 1'h0;
        pred_update_next  = 1'h0;
        if (I_FLUSH) begin
            // A flush drops whatever branch is pending
            state_next = zero_compare_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                zero_compare_pkg::ST_IDLE: begin
                    if (I_BRANCH_VALID) begin
                        if (I_RELEASE6 && cond_likely) begin
                            ri_next = 1'h1;
                        end else begin
                            state_next       = zero_compare_pkg::ST_SLOT;
                            taken_next       = cond_taken;
                            likely_next      = cond_likely;
                            target_next      = calc_target;
                            pred_valid_next  = 1'h1;
                            pred_static_next = cond_likely;
                            pred_lookup_next = !cond_likely;
                        end
                    end
                end
                zero_compare_pkg::ST_SLOT: begin
                    if (I_SLOT_VALID) begin
                        // Only dynamically predicted forms train the tables
                        pred_update_next  = !likely_reg;
                        update_taken_next = taken_reg;
                        if (I_RELEASE6 && slot_is_xfer) begin
                            ri_next      = 1'h1;
                            nullify_next = 1'h1;
                            state_next   = zero_compare_pkg::ST_IDLE;
                        end else begin
                            unpred_next = !I_RELEASE6 && slot_is_xfer;
                            if (taken_reg) begin
                                commit_next = 1'h1;
                                state_next  = zero_compare_pkg::ST_REDIRECT;
                            end else if (likely_reg) begin
                                nullify_next = 1'h1;
                                state_next   = zero_compare_pkg::ST_IDLE;
                            end else begin
                                commit_next = 1'h1;
                                state_next  = zero_compare_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                zero_compare_pkg::ST_REDIRECT: begin
                    redirect_next = 1'h1;
                    state_next    = zero_compare_pkg::ST_IDLE;
                end
                default: begin
                    state_next = zero_compare_pkg::ST_IDLE;
                end
            endcase
        end
        ready_next = (state_next == zero_compare_pkg::ST_IDLE);
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_reg        <= zero_compare_pkg::ST_IDLE;
            taken_reg        <= 1'h0;
            likely_reg       <= 1'h0;
            target_reg       <= zero_compare_pkg::TARGET_RESET;
            ready_reg        <= 1'h1;
            commit_reg       <= 1'h0;
            nullify_reg      <= 1'h0;
            unpred_reg       <= 1'h0;
            ri_reg           <= 1'h0;
            redirect_reg     <= 1'h0;
            pred_valid_reg   <= 1'h0;
            pred_static_reg  <= 1'h0;
            pred_lookup_reg  <= 1'h0;
            pred_update_reg  <= 1'h0;
            update_taken_reg <= 1'h0;
        end else begin
            state_reg        <= state_next;
            taken_reg        <= taken_next;
            likely_reg       <= likely_next;
            target_reg       <= target_next;
            ready_reg        <= ready_next;
            commit_reg       <= commit_next;
            nullify_reg      <= nullify_next;
            unpred_reg       <= unpred_next;
            ri_reg           <= ri_next;
            redirect_reg     <= redirect_next;
            pred_valid_reg   <= pred_valid_next;
            pred_static_reg  <= pred_static_next;
            pred_lookup_reg  <= pred_lookup_next;
            pred_update_reg  <= pred_update_next;
            update_taken_reg <= update_taken_next;
        end
    end

    assign O_READY                = ready_reg;
    assign O_SLOT_COMMIT          = commit_reg;
    assign O_SLOT_NULLIFY         = nullify_reg;
    assign O_SLOT_UNPREDICTABLE   = unpred_reg;
    assign O_RI_EXCEPTION         = ri_reg;
    assign O_REDIRECT             = redirect_reg;
    assign O_TARGET               = target_reg;
    assign O_PREDICT_VALID        = pred_valid_reg;
    assign O_PREDICT_STATIC_TAKEN = pred_static_reg;
    assign O_PREDICTOR_LOOKUP     = pred_lookup_reg;
    assign O_PREDICTOR_UPDATE     = pred_update_reg;
    assign O_UPDATE_TAKEN         = update_taken_reg;

    // Independent reference target for checking, built straight from the offset field
    localparam int REF_EXT = zero_compare_pkg::GENERAL_REGISTER_WIDTH - zero_compare_pkg::TARGET_OFFSET_WIDTH;
    logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0] ref_target;
    assign ref_target = I_BRANCH.pc + zero_compare_pkg::NEXT_INSTR_STEP
                        + {{REF_EXT{I_BRANCH.offset[zero_compare_pkg::OFFSET_WIDTH-1]}}, I_BRANCH.offset,
                           {zero_compare_pkg::SHIFT_AMOUNT{1'h0}}};

    property p_target;
        @(posedge I_CLOCK) disable iff (I_RST)
        branch_fire && !(I_RELEASE6 && cond_likely) |=> (O_TARGET == $past(ref_target));
    endproperty
    a_target: assert property (p_target) else $error("Branch target mismatch");

    property p_nonneg;
        @(posedge I_CLOCK) disable iff (I_RST)
        branch_fire && !I_RELEASE6 && (I_BRANCH.kind == zero_compare_pkg::BRANCH_NONNEGATIVE_LIKELY)
        |=> (taken_reg == !$past(I_BRANCH.operand[zero_compare_pkg::SIGN_BIT]));
    endproperty
    a_nonneg: assert property (p_nonneg) else $error("Nonnegative condition wrong");

    property p_slot_first;
        @(posedge I_CLOCK) disable iff (I_RST)
        slot_take && taken_reg && !(I_RELEASE6 && slot_is_xfer)
        |=> O_SLOT_COMMIT && !O_REDIRECT ##1 (O_REDIRECT || $past(I_FLUSH)) && !O_SLOT_COMMIT;
    endproperty
    a_slot_first: assert property (p_slot_first) else $error("Redirect not after slot");

    property p_likely_nullify;
        @(posedge I_CLOCK) disable iff (I_RST)
        slot_take && likely_reg && !taken_reg && !(I_RELEASE6 && slot_is_xfer)
        |=> O_SLOT_NULLIFY && !O_SLOT_COMMIT ##1 !O_REDIRECT;
    endproperty
    a_likely_nullify: assert property (p_likely_nullify) else $error("Likely slot not nullified");

    property p_positive;
        @(posedge I_CLOCK) disable iff (I_RST)
        branch_fire && !I_RELEASE6 && ((I_BRANCH.kind == zero_compare_pkg::BRANCH_POSITIVE) ||
                                       (I_BRANCH.kind == zero_compare_pkg::BRANCH_POSITIVE_LIKELY))
        |=> (taken_reg == (!$past(I_BRANCH.operand[zero_compare_pkg::SIGN_BIT]) &&
                           ($past(I_BRANCH.operand) != zero_compare_pkg::ZERO_VALUE)));
    endproperty
    a_positive: assert property (p_positive) else $error("Positive condition wrong");

    property p_nonpos;
        @(posedge I_CLOCK) disable iff (I_RST)
        branch_fire && (I_BRANCH.kind == zero_compare_pkg::BRANCH_NONPOSITIVE)
        |=> (taken_reg == ($past(I_BRANCH.operand[zero_compare_pkg::SIGN_BIT]) ||
                           ($past(I_BRANCH.operand) == zero_compare_pkg::ZERO_VALUE)));
    endproperty
    a_nonpos: assert property (p_nonpos) else $error("Nonpositive condition wrong");

    property p_slot_transfer;
        @(posedge I_CLOCK) disable iff (I_RST)
        slot_take && I_RELEASE6 && slot_is_xfer |=> O_RI_EXCEPTION && !O_SLOT_COMMIT ##1 !O_REDIRECT;
    endproperty
    a_slot_transfer: assert property (p_slot_transfer) else $error("Slot transfer not trapped");

    property p_pre6_flag;
        @(posedge I_CLOCK) disable iff (I_RST)
        slot_take && !I_RELEASE6 |=> (O_SLOT_UNPREDICTABLE == $past(slot_is_xfer)) && !O_RI_EXCEPTION;
    endproperty
    a_pre6_flag: assert property (p_pre6_flag) else $error("Unpredictable flag wrong");

    property p_no_likely6;
        @(posedge I_CLOCK) disable iff (I_RST)
        branch_fire && I_RELEASE6 && cond_likely |=> O_RI_EXCEPTION && O_READY && !O_PREDICT_VALID;
    endproperty
    a_no_likely6: assert property (p_no_likely6) else $error("Likely form accepted");

    property p_static;
        @(posedge I_CLOCK) disable iff (I_RST)
        branch_fire && cond_likely && !I_RELEASE6 |=> O_PREDICT_VALID && O_PREDICT_STATIC_TAKEN && !O_PREDICTOR_LOOKUP;
    endproperty
    a_static: assert property (p_static) else $error("Likely form used predictor");

    property p_normal_slot;
        @(posedge I_CLOCK) disable iff (I_RST)
        slot_take && !likely_reg && !(I_RELEASE6 && slot_is_xfer) |=> O_SLOT_COMMIT && O_PREDICTOR_UPDATE;
    endproperty
    a_normal_slot: assert property (p_normal_slot) else $error("Normal slot not executed");

    c_taken: cover property (@(posedge I_CLOCK) disable iff (I_RST) O_SLOT_COMMIT ##1 O_REDIRECT);
    c_nullify: cover property (@(posedge I_CLOCK) disable iff (I_RST) O_SLOT_NULLIFY && !O_RI_EXCEPTION);
    c_trap: cover property (@(posedge I_CLOCK) disable iff (I_RST) O_RI_EXCEPTION && O_SLOT_NULLIFY);
    c_unpred: cover property (@(posedge I_CLOCK) disable iff (I_RST) O_SLOT_UNPREDICTABLE);
    // A flush that lands while a branch waits for its slot or for its redirect
    c_flush: cover property (@(posedge I_CLOCK) disable iff (I_RST) I_FLUSH && !O_READY);

endmodule

// >>> hw/zero_compare_pkg.sv
// Shared types, constants and decode helpers for the compare-against-zero branch unit
package zero_compare_pkg;

    localparam int GENERAL_REGISTER_WIDTH = 32;
    localparam int OFFSET_WIDTH           = 16;
    localparam int SHIFT_AMOUNT           = 2;
    localparam int TARGET_OFFSET_WIDTH    = OFFSET_WIDTH + SHIFT_AMOUNT;
    localparam int SIGN_BIT               = GENERAL_REGISTER_WIDTH - 1;

    localparam logic [GENERAL_REGISTER_WIDTH-1:0] NEXT_INSTR_STEP = 32'h4;
    localparam logic [GENERAL_REGISTER_WIDTH-1:0] TARGET_RESET    = 32'h0;
    localparam logic [GENERAL_REGISTER_WIDTH-1:0] ZERO_VALUE      = 32'h0;

    typedef enum logic [1:0] {
        BRANCH_NONNEGATIVE_LIKELY = 2'h0,
        BRANCH_POSITIVE           = 2'h1,
        BRANCH_POSITIVE_LIKELY    = 2'h2,
        BRANCH_NONPOSITIVE        = 2'h3
    } branch_kind_t;

    // Instruction class of the delay-slot instruction, from the core decoder
    typedef enum logic [3:0] {
        SLOT_PLAIN                       = 4'h0,
        SLOT_BRANCH                      = 4'h1,
        SLOT_JUMP                        = 4'h2,
        SLOT_NOOP_AND_LINK               = 4'h3,
        SLOT_EXCEPTION_RETURN            = 4'h4,
        SLOT_EXCEPTION_RETURN_KEEP_LLBIT = 4'h5,
        SLOT_DEBUG_RETURN                = 4'h6,
        SLOT_WAIT                        = 4'h7,
        SLOT_PAUSE                       = 4'h8
    } slot_class_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h1,
        ST_SLOT     = 3'h2,
        ST_REDIRECT = 3'h4
    } unit_state_t;

    typedef struct packed {
        branch_kind_t                      kind;
        logic [GENERAL_REGISTER_WIDTH-1:0] operand;
        logic [GENERAL_REGISTER_WIDTH-1:0] pc;
        logic [OFFSET_WIDTH-1:0]           offset;
    } branch_req_t;

    function automatic logic is_control_transfer(input slot_class_t c);
        logic r;
        r = 1'h0;
        case (c)
            SLOT_BRANCH, SLOT_JUMP, SLOT_NOOP_AND_LINK, SLOT_EXCEPTION_RETURN,
            SLOT_EXCEPTION_RETURN_KEEP_LLBIT, SLOT_DEBUG_RETURN, SLOT_WAIT, SLOT_PAUSE: r = 1'h1;
            default: r = 1'h0;
        endcase
        return r;
    endfunction

    function automatic logic is_likely(input branch_kind_t k);
        return (k == BRANCH_NONNEGATIVE_LIKELY) || (k == BRANCH_POSITIVE_LIKELY);
    endfunction

endpackage

// >>> hw/zero_compare_cond.sv
// Signed compare of one general register against zero for each branch form
`timescale 1ns/10ps
module zero_compare_cond (
    // Branch form and tested value
    input  wire zero_compare_pkg::branch_kind_t                         i_kind,
    input  wire logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0]   i_operand,
    // Outcome
    output logic                                                        o_taken,
    output logic                                                        o_likely
);
    logic sign_set;
    logic is_zero;

    always_comb begin
        sign_set = i_operand[zero_compare_pkg::SIGN_BIT];
        is_zero  = (i_operand == zero_compare_pkg::ZERO_VALUE);
        o_likely = zero_compare_pkg::is_likely(i_kind);
        unique case (i_kind)
            zero_compare_pkg::BRANCH_NONNEGATIVE_LIKELY: o_taken = !sign_set;
            zero_compare_pkg::BRANCH_POSITIVE:           o_taken = !sign_set && !is_zero;
            zero_compare_pkg::BRANCH_POSITIVE_LIKELY:    o_taken = !sign_set && !is_zero;
            zero_compare_pkg::BRANCH_NONPOSITIVE:        o_taken = sign_set || is_zero;
        endcase
    end
endmodule

// >>> hw/branch_target_calc.sv
// PC-relative branch target from the shifted, sign-extended offset
`timescale 1ns/10ps
module branch_target_calc (
    // Branch address and offset field
    input  wire logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0] i_pc,
    input  wire logic [zero_compare_pkg::OFFSET_WIDTH-1:0]           i_offset,
    // Target
    output logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0]      o_target
);
    localparam int EXT = zero_compare_pkg::GENERAL_REGISTER_WIDTH - zero_compare_pkg::TARGET_OFFSET_WIDTH;

    logic [zero_compare_pkg::TARGET_OFFSET_WIDTH-1:0]    shifted;
    logic [zero_compare_pkg::GENERAL_REGISTER_WIDTH-1:0] extended;

    always_comb begin
        shifted  = {i_offset, {zero_compare_pkg::SHIFT_AMOUNT{1'h0}}};
        extended = {{EXT{shifted[zero_compare_pkg::TARGET_OFFSET_WIDTH-1]}}, shifted};
        // Relative to the delay-slot address, not the branch itself
        o_target = i_pc + zero_compare_pkg::NEXT_INSTR_STEP + extended;
    end
endmodule

// >>> bench/zero_compare_branch_unit_tb.sv
// Self-checking testbench for the compare-against-zero branch unit
`timescale 1ns/10ps
module zero_compare_branch_unit_tb;
    logic                          clk = 1'b0;
    logic                          rst = 1'b1;
    logic                          rel6 = 1'b0;
    logic                          br_valid = 1'b0;
    zero_compare_pkg::branch_req_t br = '0;
    logic                          slot_valid = 1'b0;
    zero_compare_pkg::slot_class_t slot_class = zero_compare_pkg::SLOT_PLAIN;
    logic                          flush = 1'b0;
    logic                          ready, commit, nullify, unpred, ri, redirect;
    logic                          pred_valid, static_tk, lookup, upd, upd_tk;
    logic [31:0]                   target;
    int                            num_errors = 0;
    int                            checks = 0;

    zero_compare_branch_unit i_dut (.I_CLOCK(clk), .I_RST(rst), .I_RELEASE6(rel6), .I_BRANCH_VALID(br_valid),
        .I_BRANCH(br), .I_SLOT_VALID(slot_valid), .I_SLOT_CLASS(slot_class), .I_FLUSH(flush), .O_READY(ready),
        .O_SLOT_COMMIT(commit), .O_SLOT_NULLIFY(nullify), .O_SLOT_UNPREDICTABLE(unpred), .O_RI_EXCEPTION(ri),
        .O_REDIRECT(redirect), .O_TARGET(target), .O_PREDICT_VALID(pred_valid), .O_PREDICT_STATIC_TAKEN(static_tk),
        .O_PREDICTOR_LOOKUP(lookup), .O_PREDICTOR_UPDATE(upd), .O_UPDATE_TAKEN(upd_tk));

    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One branch followed by its delay-slot instruction; expectations from the branch forms
    task automatic do_branch(input logic [1:0] k, input logic [31:0] op, input logic [31:0] pc,
                             input logic [15:0] off, input logic [3:0] cls);
        logic lk, tk, xfer;
        lk = (k == 2'h0) || (k == 2'h2);
        tk = (k == 2'h0) ? !op[31] : (k == 2'h3) ? (op[31] || op == 32'h0) : (!op[31] && op != 32'h0);
        xfer = (cls != 4'h0);
        br_valid = 1'b1;
        br = '{zero_compare_pkg::branch_kind_t'(k), op, pc, off};
        @(posedge clk); #1;
        br_valid = 1'b0;
        if (rel6 && lk) begin
            chk(ri, 1'b1, "likely form not refused");
            chk(ready, 1'b1, "not idle after refusal");
            chk(pred_valid, 1'b0, "refused form predicted");
            @(posedge clk); #1;
            chk(ri, 1'b0, "refusal pulse too long");
            return;
        end
        chk(target, pc + 32'h4 + {{14{off[15]}}, off, 2'h0}, "target");
        chk(pred_valid, 1'b1, "prediction pulse");
        chk(static_tk, lk, "static prediction");
        chk(lookup, !lk, "dynamic lookup");
        chk(ready, 1'b0, "ready while pending");
        slot_valid = 1'b1;
        slot_class = zero_compare_pkg::slot_class_t'(cls);
        @(posedge clk); #1;
        slot_valid = 1'b0;
        if (rel6 && xfer) begin
            chk(ri, 1'b1, "slot transfer not trapped");
            chk({commit, nullify}, 2'h1, "trapped slot outcome");
        end else begin
            chk(commit, tk || !lk, "slot commit");
            chk(nullify, lk && !tk, "slot nullify");
            chk({unpred, ri}, {xfer, 1'b0}, "slot flags");
        end
        chk(upd, !lk, "predictor update");
        if (!lk) chk(upd_tk, tk, "update direction");
        chk(redirect, 1'b0, "redirect before slot done");
        @(posedge clk); #1;
        chk(redirect, tk && !(rel6 && xfer), "redirect");
        chk(ready, 1'b1, "idle after branch");
    endtask

    task automatic t_conditions();
        logic [31:0] ops [5] = '{32'h0, 32'h1, 32'h7fffffff, 32'h80000000, 32'hffffffff};
        for (int k = 0; k < 4; k++) begin
            foreach (ops[i]) do_branch(k[1:0], ops[i], 32'h400, 16'h10, 4'h0);
        end
        $display("conditions test done");
    endtask

    task automatic t_target();
        logic [15:0] offs [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0000};
        foreach (offs[i]) do_branch(2'h1, 32'h5, 32'hfffffff8, offs[i], 4'h0);
        foreach (offs[i]) do_branch(2'h3, 32'h0, 32'h1000, offs[i], 4'h0);
        $display("target test done");
    endtask

    task automatic t_slot_transfer();
        for (int r = 0; r < 2; r++) begin
            rel6 = r[0];
            for (int c = 1; c < 9; c++) do_branch(2'h1, 32'h1, 32'h2000, 16'h4, c[3:0]);
            do_branch(2'h3, 32'h9, 32'h2000, 16'h4, 4'h7);
        end
        rel6 = 1'b0;
        $display("slot transfer test done");
    endtask

    task automatic t_release6_likely();
        rel6 = 1'b1;
        do_branch(2'h0, 32'h5, 32'h3000, 16'h8, 4'h0);
        do_branch(2'h2, 32'h5, 32'h3000, 16'h8, 4'h0);
        do_branch(2'h3, 32'h0, 32'h3000, 16'h8, 4'h0);
        rel6 = 1'b0;
        $display("release six likely test done");
    endtask

    task automatic t_flush();
        br_valid = 1'b1;
        br = '{zero_compare_pkg::BRANCH_POSITIVE, 32'h1, 32'h500, 16'h2};
        @(posedge clk); #1;
        br_valid = 1'b0;
        flush = 1'b1;
        slot_valid = 1'b1;
        @(posedge clk); #1;
        flush = 1'b0;
        slot_valid = 1'b0;
        chk({commit, nullify, ready}, 3'h1, "flush outcome");
        @(posedge clk); #1;
        chk(redirect, 1'b0, "redirect after flush");
        do_branch(2'h1, 32'h1, 32'h500, 16'h2, 4'h0);
        $display("flush test done");
    endtask

    // Reset while a branch waits for its slot drops it and restores the idle outputs
    task automatic t_reset();
        br_valid = 1'b1;
        br = '{zero_compare_pkg::BRANCH_POSITIVE, 32'h1, 32'h600, 16'h3};
        @(posedge clk); #1;
        br_valid = 1'b0;
        rst = 1'b1;
        #1;
        chk({ready, pred_valid, lookup}, 3'h4, "outputs during reset");
        chk(target, 32'h0, "target during reset");
        @(posedge clk); #1;
        rst = 1'b0;
        @(posedge clk); #1;
        chk({ready, commit, nullify, redirect}, 4'h8, "branch dropped by reset");
        do_branch(2'h1, 32'h1, 32'h600, 16'h3, 4'h0);
        $display("reset test done");
    endtask

    initial begin
        #20000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        chk({ready, pred_valid, commit, nullify, redirect, ri}, 6'h20, "reset outputs");
        chk(target, 32'h0, "reset target");
        t_conditions();
        t_target();
        t_slot_transfer();
        t_release6_likely();
        t_flush();
        t_reset();
        print_verdict();
    end
endmodule
